// ---- bfs_pkg.sv ----
// Purpose: shared constants and types of the buck fault supervisor
// Assumes: 125 MHz ref_clk, all protection delays built on a 4 us tick except the 2 us power-ok drop
// Notes:   tick counts are derived from the printed times in their units
package bfs_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_NS = 4000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int UV_DELAY_US = 1000;
    localparam int UV_BLANK_US = 1500;
    localparam int PG_RISE_US = 1000;
    localparam int PG_FALL_NS = 2000;
    localparam int SS0_US = 700;
    localparam int SS1_US = 1400;
    localparam int SS2_US = 2800;
    localparam int SS3_US = 5600;
    localparam int HIC_BASE = 257;
    localparam int HIC_EXP_MIN = 8;
    localparam int HIC_WAITS = 7;

    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] UV_DELAY_TICKS =
        CNT_W'(UV_DELAY_US * 1000 / TICK_NS);
    localparam logic [CNT_W-1:0] UV_BLANK_TICKS =
        CNT_W'(UV_BLANK_US * 1000 / TICK_NS);
    localparam logic [CNT_W-1:0] PG_RISE_TICKS =
        CNT_W'(PG_RISE_US * 1000 / TICK_NS);
    localparam logic [CNT_W-1:0] PG_FALL_CYC =
        CNT_W'(PG_FALL_NS / CLK_PERIOD_NS);

    // comparator flag positions in the synchronised vector
    localparam int NFLAGS = 9;
    localparam int F_EN = 0;
    localparam int F_WIN = 1;
    localparam int F_OUTER = 2;
    localparam int F_UV = 3;
    localparam int F_OV = 4;
    localparam int F_BOV = 5;
    localparam int F_OC = 6;
    localparam int F_BIAS = 7;
    localparam int F_THERM = 8;

    // register map, byte addresses
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_COUNT = 4'h8;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_PG_BIT = 4;
    localparam int ST_HS_BIT = 5;
    localparam int ST_LS_BIT = 6;
    localparam int ST_DIS_BIT = 7;
    localparam int ST_UVARM_BIT = 8;
    localparam int ST_FLAG_LSB = 16;

    typedef enum logic [2:0] {
        BFS_IDLE,
        BFS_SOFT,
        BFS_RUN,
        BFS_OVPULL,
        BFS_HICCUP,
        BFS_LATCH
    } bfs_mode_t;
endpackage

// ---- bfs_stage_model.sv ----
// Purpose: behavioural power stage with window comparators
// Assumes: output level in percent of target, one step per clock
// Notes:   level only rises while the high side may switch
`timescale 1ns/1ps
`default_nettype none
module bfs_stage_model (
    input  wire logic       ref_clk,     // clock
    input  wire logic       hsPermit,    // high side allowed
    input  wire logic       lsForceOn,   // low side pulling down
    input  wire logic [7:0] tgtPct,      // level the loop settles at
    output logic            pgWindowIn,  // 95..110 percent
    output logic            pgOuterIn,   // 90..115 percent
    output logic            uvCmpIn,     // below 70 percent
    output logic            ovCmpIn      // above 120 percent
);
    logic [7:0] level_r = 8'h00;
    always_ff @(posedge ref_clk) begin
        // no switching: the load drains the output
        if ((!hsPermit || lsForceOn) && level_r != 8'h00)
            level_r <= level_r - 8'h01;
        else if (hsPermit && !lsForceOn && level_r < tgtPct)
            level_r <= level_r + 8'h01;
        else if (hsPermit && !lsForceOn && level_r > tgtPct)
            level_r <= level_r - 8'h01;
    end
    assign pgWindowIn = level_r >= 8'h5F && level_r <= 8'h6E;
    assign pgOuterIn  = level_r >= 8'h5A && level_r <= 8'h73;
    assign uvCmpIn    = level_r < 8'h46;
    assign ovCmpIn    = level_r > 8'h78;
endmodule
`default_nettype wire

// ---- bfs_supervisor.sv ----
// Purpose: fault supervisor for a synchronous buck power stage
// Assumes: comparator flags are asynchronous levels; Avalon-MM slave
// Notes:   all delays count 4 us ticks except the 2 us power-ok drop
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bfs_supervisor #(
    parameter int TICK_CYCLES = bfs_pkg::TICK_CYCLES
) (
    input  wire logic        ref_clk, // 125 MHz clock
    input  wire logic        reset_n, // async reset, active low
    input  wire logic        enableIn, // enable pin, high = on
    input  wire logic        pgWindowIn, // output in -5%..+10%
    input  wire logic        pgOuterIn, // output in -10%..+15%
    input  wire logic        uvCmpIn, // feedback below 70%
    input  wire logic        ovCmpIn, // feedback above 120%
    input  wire logic        backupOvIn, // backup sense above 120%
    input  wire logic        overCurIn, // inductor current over trip
    input  wire logic        biasLockoutIn, // bias rail below lockout
    input  wire logic        thermalIn, // die over temperature
    output logic             hsPermit, // high-side turn-on allowed
    output logic             lsPermit, // low-side drive allowed
    output logic             lsForceOn, // low side forced on
    output logic             dischargeOn, // output discharge switch
    output logic             softStartRun, // reference ramp running
    output logic             powerOkOut, // power-ok pin drive value
    output logic             powerOkOeN, // power-ok pull-down, low=on
    input  wire logic [3:0]  avsAddress, // byte address
    input  wire logic        avsRead, // read strobe
    input  wire logic        avsWrite, // write strobe
    input  wire logic [3:0]  avsByteenable, // byte lanes
    input  wire logic [31:0] avsWritedata, // write data
    output logic      [31:0] avsReaddata, // read data
    output logic             avsWaitrequest  // stall
);
    localparam int CW = bfs_pkg::CNT_W;

    typedef struct packed {
        bfs_pkg::bfs_mode_t mode;
        logic [CW-1:0]      phaseCnt;
        logic [CW-1:0]      blankCnt;
        logic [CW-1:0]      uvCnt;
        logic [CW-1:0]      pgCnt;
        logic [CW-1:0]      pgFallCnt;
        logic               pgOk;
        logic               ovBackup;
        logic               hs;
        logic               ls;
        logic               lsForce;
        logic               discharge;
        logic [1:0]         ssSel;
        logic [15:0]        restarts;
        logic               busAck;
        logic [31:0]        rdData;
    } bfs_state_t;

    bfs_state_t s_r;
    bfs_state_t s_nxt;

    logic [bfs_pkg::NFLAGS-1:0] rawFlags;
    logic [bfs_pkg::NFLAGS-1:0] flags;
    logic                       tick;

    assign rawFlags = {thermalIn, biasLockoutIn, overCurIn, backupOvIn,
                       ovCmpIn, uvCmpIn, pgOuterIn, pgWindowIn, enableIn};

    bfs_sync #(
        .WIDTH (bfs_pkg::NFLAGS)
    ) u_sync (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .asyncIn (rawFlags),
        .syncOut (flags)
    );

    bfs_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .tick    (tick)
    );

    function automatic logic [CW-1:0] ssTicks(input logic [1:0] sel);
        int us;
        case (sel)
            2'h0:    us = bfs_pkg::SS0_US;
            2'h1:    us = bfs_pkg::SS1_US;
            2'h2:    us = bfs_pkg::SS2_US;
            default: us = bfs_pkg::SS3_US;
        endcase
        return CW'(us * 1000 / bfs_pkg::TICK_NS);
    endfunction

    // seven waits of (2^n + 257) ticks, n tracks the soft-start choice
    function automatic logic [CW-1:0] hiccupTicks(input logic [1:0] sel);
        logic [CW-1:0] w;
        w = (CW'(1) << (bfs_pkg::HIC_EXP_MIN + int'(sel)))
            + CW'(bfs_pkg::HIC_BASE);
        return CW'(bfs_pkg::HIC_WAITS) * w;
    endfunction

    function automatic logic isReg(input logic [3:0] a,
                                   input logic [3:0] off);
        return a[3:2] == off[3:2];
    endfunction

    logic enS;
    logic faultHold;
    logic uvArmed;
    logic ovAny;
    logic running;
    logic [31:0] statusWord;

    always_comb begin
        enS       = flags[bfs_pkg::F_EN];
        faultHold = flags[bfs_pkg::F_BIAS] | flags[bfs_pkg::F_THERM];
        uvArmed   = (s_r.blankCnt == bfs_pkg::UV_BLANK_TICKS);
        ovAny     = flags[bfs_pkg::F_OV] | flags[bfs_pkg::F_BOV];
        statusWord = '0;
        statusWord[bfs_pkg::ST_MODE_LSB +: 3] = s_r.mode;
        statusWord[bfs_pkg::ST_PG_BIT] = s_r.pgOk;
        statusWord[bfs_pkg::ST_HS_BIT] = s_r.hs;
        statusWord[bfs_pkg::ST_LS_BIT] = s_r.ls;
        statusWord[bfs_pkg::ST_DIS_BIT] = s_r.discharge;
        statusWord[bfs_pkg::ST_UVARM_BIT] = uvArmed;
        statusWord[bfs_pkg::ST_FLAG_LSB +: bfs_pkg::NFLAGS] = flags;
    end

    always_comb begin
        s_nxt = s_r;

        // one wait state, then the registered answer stands
        s_nxt.busAck = 1'b0;
        if ((avsRead || avsWrite) && !s_r.busAck) begin
            s_nxt.busAck = 1'b1;
            s_nxt.rdData = '0;
            if (avsRead) begin
                if (isReg(avsAddress, bfs_pkg::REG_CTRL)) begin
                    s_nxt.rdData = {30'h0, s_r.ssSel};
                end else if (isReg(avsAddress, bfs_pkg::REG_STATUS)) begin
                    s_nxt.rdData = statusWord;
                end else if (isReg(avsAddress, bfs_pkg::REG_COUNT)) begin
                    s_nxt.rdData = {16'h0, s_r.restarts};
                end
            end
        end
        // write lands on the edge that sees waitrequest low
        if (avsWrite && s_r.busAck && avsByteenable[0]
            && isReg(avsAddress, bfs_pkg::REG_CTRL)) begin
            s_nxt.ssSel = avsWritedata[1:0];
        end

        case (s_r.mode)
            bfs_pkg::BFS_IDLE: begin
                if (enS && !faultHold) begin
                    s_nxt.mode     = bfs_pkg::BFS_SOFT;
                    s_nxt.phaseCnt = '0;
                end
            end
            bfs_pkg::BFS_SOFT: begin
                if (ovAny) begin
                    s_nxt.mode     = bfs_pkg::BFS_OVPULL;
                    s_nxt.ovBackup = !flags[bfs_pkg::F_OV];
                    s_nxt.uvCnt    = '0;
                end else if (tick) begin
                    s_nxt.phaseCnt = s_r.phaseCnt + CW'(1);
                    if (s_r.phaseCnt + CW'(1) >= ssTicks(s_r.ssSel)) begin
                        s_nxt.mode     = bfs_pkg::BFS_RUN;
                        s_nxt.blankCnt = '0;
                        s_nxt.uvCnt    = '0;
                        s_nxt.pgCnt    = '0;
                    end
                end
            end
            bfs_pkg::BFS_RUN: begin
                if (tick && !uvArmed) begin
                    s_nxt.blankCnt = s_r.blankCnt + CW'(1);
                end
                if (ovAny) begin
                    s_nxt.mode     = bfs_pkg::BFS_OVPULL;
                    s_nxt.ovBackup = !flags[bfs_pkg::F_OV];
                    s_nxt.uvCnt    = '0;
                end else if (uvArmed && flags[bfs_pkg::F_UV]) begin
                    if (tick) begin
                        s_nxt.uvCnt = s_r.uvCnt + CW'(1);
                        if (s_r.uvCnt + CW'(1) >= bfs_pkg::UV_DELAY_TICKS)
                        begin
                            s_nxt.mode     = bfs_pkg::BFS_HICCUP;
                            s_nxt.phaseCnt = '0;
                        end
                    end
                end else begin
                    s_nxt.uvCnt = '0;
                end
            end
            bfs_pkg::BFS_OVPULL: begin
                if (flags[bfs_pkg::F_UV]) begin
                    if (s_r.ovBackup) begin
                        s_nxt.mode = bfs_pkg::BFS_LATCH;
                    end else if (tick) begin
                        s_nxt.uvCnt = s_r.uvCnt + CW'(1);
                        if (s_r.uvCnt + CW'(1) >= bfs_pkg::UV_DELAY_TICKS)
                        begin
                            s_nxt.mode = bfs_pkg::BFS_LATCH;
                        end
                    end
                end else begin
                    s_nxt.uvCnt = '0;
                end
            end
            bfs_pkg::BFS_HICCUP: begin
                if (tick) begin
                    s_nxt.phaseCnt = s_r.phaseCnt + CW'(1);
                    if (s_r.phaseCnt + CW'(1) >= hiccupTicks(s_r.ssSel))
                    begin
                        s_nxt.mode     = bfs_pkg::BFS_SOFT;
                        s_nxt.phaseCnt = '0;
                        s_nxt.restarts = s_r.restarts + 16'h0001;
                    end
                end
            end
            bfs_pkg::BFS_LATCH: begin
                // held until enable drops or a lockout clears the latch
            end
            default: begin
                s_nxt.mode = bfs_pkg::BFS_IDLE;
            end
        endcase

        // non-latching shutdowns override everything, incl. latches
        if (!enS || faultHold) begin
            s_nxt.mode     = bfs_pkg::BFS_IDLE;
            s_nxt.phaseCnt = '0;
            s_nxt.uvCnt    = '0;
            s_nxt.blankCnt = '0;
        end

        // power-ok judged only while regulating after soft-start
        if (s_nxt.mode == bfs_pkg::BFS_RUN
            && s_r.mode == bfs_pkg::BFS_RUN) begin
            if (!s_r.pgOk) begin
                s_nxt.pgFallCnt = '0;
                if (flags[bfs_pkg::F_WIN]) begin
                    if (tick) begin
                        s_nxt.pgCnt = s_r.pgCnt + CW'(1);
                        if (s_r.pgCnt + CW'(1) >= bfs_pkg::PG_RISE_TICKS)
                        begin
                            s_nxt.pgOk = 1'b1;
                        end
                    end
                end else begin
                    s_nxt.pgCnt = '0;
                end
            end else if (!flags[bfs_pkg::F_OUTER]) begin
                s_nxt.pgFallCnt = s_r.pgFallCnt + CW'(1);
                if (s_r.pgFallCnt + CW'(1) >= bfs_pkg::PG_FALL_CYC) begin
                    s_nxt.pgOk      = 1'b0;
                    s_nxt.pgCnt     = '0;
                    s_nxt.pgFallCnt = '0;
                end
            end else begin
                s_nxt.pgFallCnt = '0;
            end
        end else begin
            s_nxt.pgOk      = 1'b0;
            s_nxt.pgCnt     = '0;
            s_nxt.pgFallCnt = '0;
        end

        running = (s_nxt.mode == bfs_pkg::BFS_SOFT)
                  || (s_nxt.mode == bfs_pkg::BFS_RUN);
        // valley limit: off time stretches while current is over trip
        s_nxt.hs        = running && !flags[bfs_pkg::F_OC];
        s_nxt.ls        = running
                          || (s_nxt.mode == bfs_pkg::BFS_OVPULL);
        s_nxt.lsForce   = (s_nxt.mode == bfs_pkg::BFS_OVPULL);
        s_nxt.discharge = !enS;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r       <= '0;
            s_r.mode  <= bfs_pkg::BFS_IDLE;
            s_r.ssSel <= bfs_pkg::CTRL_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hsPermit       = s_r.hs;
    assign lsPermit       = s_r.ls;
    assign lsForceOn      = s_r.lsForce;
    assign dischargeOn    = s_r.discharge;
    assign softStartRun   = (s_r.mode == bfs_pkg::BFS_SOFT);
    assign powerOkOut     = 1'b0;
    assign powerOkOeN     = s_r.pgOk;
    assign avsReaddata    = s_r.rdData;
    assign avsWaitrequest = (avsRead || avsWrite) && !s_r.busAck;
endmodule
`default_nettype wire

// ---- bfs_supervisor_chk.sv ----
// Purpose: port-level checks of the buck fault supervisor
// Assumes: flags reach outputs three edges after they change
// Notes:   counters allow a few cycles of sync and tick slack
`timescale 1ns/1ps
`default_nettype none
module bfs_supervisor_chk #(
    parameter int TICK_CYCLES = bfs_pkg::TICK_CYCLES
) (
    input wire logic ref_clk, // clock
    input wire logic reset_n, // async reset, active low
    input wire logic enableIn, // enable pin
    input wire logic pgWindowIn, // inner window
    input wire logic pgOuterIn, // outer window
    input wire logic uvCmpIn, // below 70%
    input wire logic ovCmpIn, // above 120%
    input wire logic overCurIn, // over trip
    input wire logic biasLockoutIn, // bias lockout
    input wire logic thermalIn, // over temperature
    input wire logic hsPermit, // high side allowed
    input wire logic lsPermit, // low side allowed
    input wire logic lsForceOn, // low side forced
    input wire logic dischargeOn, // discharge switch
    input wire logic softStartRun, // soft-start running
    input wire logic powerOkOut, // power-ok drive value
    input wire logic powerOkOeN // power-ok pull-down, low=on
);
    localparam int RISE_MIN  = 249 * TICK_CYCLES;
    localparam int LATCH_MAX = 252 * TICK_CYCLES + 8;
    int winHi_r;
    int outerLo_r;
    int pullUv_r;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            winHi_r <= 0;
            outerLo_r <= 0;
            pullUv_r <= 0;
        end else begin
            winHi_r <= pgWindowIn ? winHi_r + 1 : 0;
            outerLo_r <= pgOuterIn ? 0 : outerLo_r + 1;
            pullUv_r <= (lsForceOn && uvCmpIn) ? pullUv_r + 1 : 0;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_lowEn; !enableIn [*5]; endsequence
    sequence s_ovHeld; ovCmpIn [*4]; endsequence
    AST_EN_LOW: assert property (s_lowEn |-> dischargeOn && !hsPermit)
        else $error("enable low without discharge");
    AST_DIS_ONLY: assert property (enableIn [*5] |-> !dischargeOn)
        else $error("discharge while enabled");
    AST_PG_SOFT: assert property (softStartRun |-> !powerOkOeN)
        else $error("power-ok during soft-start");
    AST_PG_RISE: assert property ($rose(powerOkOeN) |-> winHi_r >= RISE_MIN)
        else $error("power-ok rose early");
    AST_PG_FALL: assert property (outerLo_r > 258 |-> !powerOkOeN)
        else $error("power-ok held outside window");
    AST_PG_OD: assert property (powerOkOut == 1'b0)
        else $error("power-ok driven high");
    AST_OC: assert property (overCurIn [*4] |-> !hsPermit)
        else $error("high side allowed in overcurrent");
    AST_OV: assert property (s_ovHeld |-> !hsPermit && (lsForceOn || !lsPermit))
        else $error("overvoltage not pulled down");
    AST_LS_FORCE: assert property (lsForceOn |-> lsPermit && !hsPermit)
        else $error("forced low side inconsistent");
    AST_OV_LATCH: assert property (pullUv_r <= LATCH_MAX)
        else $error("pull-down not latched off");
    AST_LOCK: assert property (biasLockoutIn [*4] |-> !lsPermit && !softStartRun)
        else $error("running in bias lockout");
    AST_HOT: assert property (thermalIn [*4] |-> !hsPermit && !lsPermit)
        else $error("running over temperature");
endmodule
bind bfs_supervisor bfs_supervisor_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .ref_clk, .reset_n, .enableIn, .pgWindowIn, .pgOuterIn, .uvCmpIn,
    .ovCmpIn, .overCurIn, .biasLockoutIn, .thermalIn, .hsPermit, .lsPermit,
    .lsForceOn, .dischargeOn, .softStartRun, .powerOkOut, .powerOkOeN);
`default_nettype wire

// ---- bfs_sync.sv ----
// Purpose: two-flop synchroniser bank for asynchronous comparator flags
// Assumes: flags are quasi-static levels from analog comparators
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module bfs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,   // system clock
    input  wire logic             reset_n,   // async reset, active low
    input  wire logic [WIDTH-1:0] asyncIn,   // raw flags
    output logic      [WIDTH-1:0] syncOut    // synchronised flags
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } bfs_sync_st_t;

    bfs_sync_st_t s_r;
    bfs_sync_st_t s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.meta = asyncIn;
        s_nxt.sync = s_r.meta;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign syncOut = s_r.sync;
endmodule
`default_nettype wire

// ---- bfs_tick.sv ----
// Purpose: internal timebase, one-cycle pulse every TICK_CYCLES clocks
// Assumes: TICK_CYCLES is at least 2
// Notes:   shortening TICK_CYCLES scales every protection delay together except the 250-clock power-ok drop
`timescale 1ns/1ps
`default_nettype none
module bfs_tick #(
    parameter int TICK_CYCLES = bfs_pkg::TICK_CYCLES
) (
    input  wire logic ref_clk,   // system clock
    input  wire logic reset_n,   // async reset, active low
    output logic      tick       // one-cycle pulse
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        pulse;
    } bfs_tick_st_t;

    bfs_tick_st_t s_r;
    bfs_tick_st_t s_nxt;

    always_comb begin
        s_nxt       = s_r;
        s_nxt.pulse = 1'b0;
        if (s_r.cnt == 16'(TICK_CYCLES - 1)) begin
            s_nxt.cnt   = '0;
            s_nxt.pulse = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.pulse;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: self-checking bench of the buck fault supervisor
// Assumes: short tick so hiccup waits fit a brief run
// Notes:   tick-based expectations scale with TC; the power-ok drop is 250 clocks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int TC  = 4;
    localparam int TOL = 16;
    logic ref_clk = 1'b0, reset_n = 1'b0, enableIn = 1'b0, backupOvIn = 1'b0;
    logic overCurIn = 1'b0, biasLockoutIn = 1'b0, thermalIn = 1'b0;
    logic avsRead = 1'b0, avsWrite = 1'b0;
    logic [7:0]  tgtPct = 8'h64;
    logic [3:0]  avsAddress = 4'h0, avsByteenable = 4'h0;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata, rd;
    logic avsWaitrequest, hsPermit, lsPermit, lsForceOn, dischargeOn;
    logic softStartRun, powerOkOut, powerOkOeN;
    logic pgWindowIn, pgOuterIn, uvCmpIn, ovCmpIn;
    int   err_total = 0, check_count = 0, n;
    wire  pgPin = powerOkOeN ? 1'b1 : powerOkOut;
    always #4 ref_clk = ~ref_clk;
    bfs_supervisor #(.TICK_CYCLES(TC)) dut (
        .ref_clk, .reset_n, .enableIn, .pgWindowIn, .pgOuterIn, .uvCmpIn,
        .ovCmpIn, .backupOvIn, .overCurIn, .biasLockoutIn, .thermalIn,
        .hsPermit, .lsPermit, .lsForceOn, .dischargeOn, .softStartRun,
        .powerOkOut, .powerOkOeN, .avsAddress, .avsRead, .avsWrite,
        .avsByteenable, .avsWritedata, .avsReaddata, .avsWaitrequest);
    bfs_stage_model stage (.ref_clk, .hsPermit, .lsForceOn, .tgtPct,
        .pgWindowIn, .pgOuterIn, .uvCmpIn, .ovCmpIn);
    task automatic chk(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            err_total++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask
    function automatic bit near(input int k, input int e);
        return k >= e - TOL && k <= e + TOL;
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic bus(input bit wr, input logic [3:0] a, input logic [3:0] be,
                       input logic [31:0] wd, output logic [31:0] d);
        int k;
        @(posedge ref_clk);
        avsAddress <= a;
        avsByteenable <= be;
        avsWritedata <= wd;
        avsRead <= !wr;
        avsWrite <= wr;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (avsWaitrequest !== 1'b0 && k < 20);
        d = avsReaddata;
        avsRead  <= 1'b0;
        avsWrite <= 1'b0;
        chk(k < 20, "bus stalled");
    endtask
    // values seen just after an edge are still those the edge sampled
    task automatic waitc(input int lim, ref logic s, input logic v,
                         output int k);
        k = 0;
        while (s !== v && k < lim) begin
            @(posedge ref_clk);
            k++;
        end
    endtask
    task automatic bring_up(input int s, output int k);
        logic [31:0] d;
        bus(1, bfs_pkg::REG_CTRL, 4'h1, 32'(s), d);
        enableIn <= 1'b1;
        waitc(20, softStartRun, 1'b1, k);
        chk(k < 20 && powerOkOeN === 1'b0 && dischargeOn === 1'b0, "start");
        waitc(6000, softStartRun, 1'b0, k);
    endtask
    task automatic shutdown;
        int k;
        enableIn <= 1'b0;
        waitc(10, dischargeOn, 1'b1, k);
        chk(k < 10 && hsPermit === 1'b0 && lsPermit === 1'b0, "disable");
        repeat (200) @(posedge ref_clk);
    endtask
    task automatic t_reset;
        chk(hsPermit === 1'b0 && powerOkOeN === 1'b0, "reset outputs");
        bus(0, bfs_pkg::REG_CTRL, 4'hF, 32'h0, rd);
        chk(rd === 32'h0, "ctrl reset value");
        bus(1, bfs_pkg::REG_CTRL, 4'h0, 32'h3, rd);
        bus(1, bfs_pkg::REG_STATUS, 4'hF, 32'hFFFF_FFFF, rd);
        bus(0, bfs_pkg::REG_CTRL, 4'hF, 32'h0, rd);
        chk(rd === 32'h0, "ctrl written without lane");
        bus(0, 4'hC, 4'hF, 32'h0, rd);
        chk(rd === 32'h0, "unmapped read");
        bus(0, bfs_pkg::REG_STATUS, 4'hF, 32'h0, rd);
        chk(rd[8:0] === 9'h080, "idle status");
        $display("test reset done");
    endtask
    task automatic t_soft;
        for (int s = 0; s < 4; s++) begin
            bring_up(s, n);
            chk(near(n, (175 * TC) << s), "soft-start length");
            if (s == 0) begin
                waitc(1200, powerOkOeN, 1'b1, n);
                chk(near(n, 250 * TC), "power-ok rise");
            end
            shutdown();
        end
        $display("test soft-start done");
    endtask
    task automatic t_pg;
        bring_up(0, n);
        waitc(1200, powerOkOeN, 1'b1, n);
        tgtPct <= 8'h70;
        repeat (400) @(posedge ref_clk);
        chk(powerOkOeN === 1'b1 && pgPin === 1'b1, "pg in outer");
        tgtPct <= 8'h76;
        waitc(50, pgOuterIn, 1'b0, n);
        waitc(300, powerOkOeN, 1'b0, n);
        chk(near(n, 250) && pgPin === 1'b0, "pg drop");
        tgtPct <= 8'h64;
        shutdown();
        $display("test power-ok done");
    endtask
    task automatic t_hiccup;
        bring_up(0, n);
        overCurIn <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk(hsPermit === 1'b0 && lsPermit === 1'b1, "oc off time");
        waitc(3000, lsPermit, 1'b0, n);
        chk(near(n, 625 * TC) && dischargeOn === 1'b0, "uv latch");
        waitc(16000, softStartRun, 1'b1, n);
        chk(near(n, 7 * 513 * TC) && powerOkOeN === 1'b0, "hiccup");
        waitc(1000, softStartRun, 1'b0, n);
        waitc(3000, lsPermit, 1'b0, n);
        chk(near(n, 625 * TC), "repeat latch");
        bus(0, bfs_pkg::REG_COUNT, 4'hF, 32'h0, rd);
        chk(rd[15:0] === 16'h0001, "restart count");
        overCurIn <= 1'b0;
        shutdown();
        $display("test hiccup done");
    endtask
    task automatic t_ov(input bit bk);
        bring_up(0, n);
        repeat (1600) @(posedge ref_clk);
        if (bk) backupOvIn <= 1'b1;
        else tgtPct <= 8'h82;
        waitc(100, lsForceOn, 1'b1, n);
        chk(n < 100 && hsPermit === 1'b0 && !dischargeOn, "ov");
        waitc(200, uvCmpIn, 1'b1, n);
        waitc(1200, lsPermit, 1'b0, n);
        chk(bk ? n < 20 : near(n, 250 * TC), "ov latch");
        repeat (2000) @(posedge ref_clk);
        chk(lsPermit === 1'b0 && softStartRun === 1'b0, "latched");
        backupOvIn <= 1'b0;
        tgtPct <= 8'h64;
        shutdown();
        $display("test overvoltage done");
    endtask
    task automatic t_lock(input bit th);
        bring_up(0, n);
        if (th) thermalIn <= 1'b1;
        else biasLockoutIn <= 1'b1;
        waitc(10, lsPermit, 1'b0, n);
        chk(n < 10 && hsPermit === 1'b0 && !dischargeOn, "lock");
        repeat (50) @(posedge ref_clk);
        thermalIn <= 1'b0;
        biasLockoutIn <= 1'b0;
        waitc(10, softStartRun, 1'b1, n);
        chk(n < 10, "restart after lock");
        shutdown();
        $display("test lockout done");
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        t_soft();
        t_pg();
        t_hiccup();
        t_ov(1'b0);
        t_ov(1'b1);
        t_lock(1'b0);
        t_lock(1'b1);
        tally_and_finish();
    end
    // whole sequence needs about 50k cycles
    initial begin
        #650us;
        err_total++;
        $display("mismatch %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire
